/* File: hw/eipv_ctrl.sv */
// External interrupt poll and vectoring controller, with Wishbone register access.
// Assumes device controllers on a daisy-chained poll line answer asynchronously,
// holding the device number stable while its valid strobe is high.
//
// Summary of operation
// - Internal handlers live in segment 1; device handlers must use another segment.
// - A pending external interrupt is recorded in extended status bit 8.
// - The external interrupt parameter is the interrupting device number.
// - Stack overflow vectors via entry 30 octal, user traps via entry 31 octal.
// - User trap parameter is a cause code from 1 to 5 or 10 to 20 octal.
// - User traps are taken only while the status trap enable bit is set.
// - Interrupt stack markers hold six words; parameter sits at marker plus 3.
// - Dispatcher delta-Q word reads zero in bits 1-15; bit 0 is settable.
// - Dispatcher flag set on dispatcher entry, cleared on finish or interrupt.
// - Interrupt stack flag set on switching to it, held while it is current.
// - Stack base/limit at words 5,6 for CPU 1, 11,12 octal for CPU 2.
// - Base value addresses the dispatcher delta-Q word; limit bounds the stack.
// - External handlers run with external interrupts enabled, internal ones disabled.
// - The poll activates only the highest priority requesting controller.
// - Nonzero number: latch it, signal CPU, set bit 8, release the poll.
// - Zero number: ignore, release the poll, do not notify the CPU.
// - Label from second DEVICE_REFERENCE_TABLE word selects code segment; transfer entry gives start.
// - Interrupt exit from external code sends reset to the interrupting controller.
// - Internal interrupt entry loads status with octal 100001.
// - External interrupt entry loads status with octal 140000.
// - Priority follows poll chain position only, never the device number.
`timescale 1ns/10ps
`default_nettype none
module eipv_ctrl (
  // Clock and reset
  input  wire logic                 SYS_CLK,
  input  wire logic                 RST_N,
  // Wishbone slave
  input  wire logic                 CYC_I,
  input  wire logic                 STB_I,
  input  wire logic                 WE_I,
  input  wire logic [7:0]           ADR_I,
  input  wire logic [3:0]           SEL_I,
  input  wire logic [31:0]          DAT_I,
  output var  logic [31:0]          DAT_O,
  output var  logic                 ACK_O,
  // Poll chain toward device controllers
  input  wire logic                 INT_REQ,
  input  wire logic                 DEV_NUM_VALID,
  input  wire logic [7:0]           DEV_NUM,
  output var  logic                 INT_POLL,
  // Reset command toward the interrupting controller
  output var  logic                 DEV_RESET,
  output var  logic [7:0]           DEV_RESET_NUM,
  // CPU side
  output var  logic                 CPU_EXT_INT
);

  // ==========================================================
  // Pin synchronisers
  logic       req_s1_reg, req_s2_reg, vld_s1_reg, vld_s2_reg;
  logic [7:0] num_s1_reg, num_s2_reg;

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      vld_s1_reg <= 1'b0;
      vld_s2_reg <= 1'b0;
      num_s1_reg <= 8'h00;
      num_s2_reg <= 8'h00;
    end
    else
    begin
      req_s1_reg <= INT_REQ;
      req_s2_reg <= req_s1_reg;
      vld_s1_reg <= DEV_NUM_VALID;
      vld_s2_reg <= vld_s1_reg;
      num_s1_reg <= DEV_NUM;
      num_s2_reg <= num_s1_reg;
    end
  end

  // ==========================================================
  // Functions
  function automatic logic trap_cause_ok(input logic [4:0] c);
    trap_cause_ok = ((c >= eipv_pkg::TRAP_FIRST) && (c <= eipv_pkg::TRAP_GAP_LO)) ||
                    ((c >= eipv_pkg::TRAP_GAP_HI) && (c <= eipv_pkg::TRAP_LAST));
  endfunction : trap_cause_ok

  function automatic logic [15:0] drt_word(input logic [7:0] dev, input logic [15:0] ofs);
    drt_word = {6'h00, dev, 2'b00} + ofs;
  endfunction : drt_word

  // ==========================================================
  // Bus decode
  logic        ack_reg;
  logic        bus_req;
  logic        wr_hit;
  logic [15:0] wdata;
  logic        wr_cmd;
  eipv_pkg::eipv_cmd_t cmd;

  assign bus_req = CYC_I && STB_I && !ack_reg;
  assign wr_hit  = bus_req && WE_I;
  assign wdata   = {SEL_I[1] ? DAT_I[15:8] : 8'h00, SEL_I[0] ? DAT_I[7:0] : 8'h00};
  assign wr_cmd  = wr_hit && (ADR_I == eipv_pkg::OFS_CMD) && SEL_I[0];
  assign cmd     = wr_cmd ? eipv_pkg::eipv_cmd_t'(DAT_I[3:0]) : eipv_pkg::CMD_NONE;

  // ==========================================================
  // Core state
  logic [15:0] status_reg;
  logic        pend_reg, ics_reg, disp_reg, ext_act_reg, lbl_err_reg, cpu_sel_reg, dq_b0_reg;
  logic [7:0]  int_addr_reg, stt_reg;
  logic [15:0] param_reg;
  logic        ics_mark_reg;
  logic        dev_rst_reg;
  logic [7:0]  dev_rst_num_reg;
  logic        trap_take, poll_latch;
  eipv_pkg::eipv_poll_t poll_reg, poll_next;

  assign trap_take  = (cmd == eipv_pkg::CMD_USER_TRAP) && trap_cause_ok(DAT_I[12:8]) &&
                      status_reg[eipv_pkg::STATUS_TRAP_BIT];
  assign poll_latch = (poll_reg == eipv_pkg::POLL_WAIT) && vld_s2_reg && (num_s2_reg != 8'h00);

  // ==========================================================
  // Poll sequencer
  always_comb
  begin
    poll_next = poll_reg;
    case (poll_reg)
      eipv_pkg::POLL_IDLE:
        if (req_s2_reg && !pend_reg)
          poll_next = eipv_pkg::POLL_WAIT;
      eipv_pkg::POLL_WAIT:
        if (vld_s2_reg)
          poll_next = eipv_pkg::POLL_DROP;
      eipv_pkg::POLL_DROP:
        if (!vld_s2_reg)
          poll_next = eipv_pkg::POLL_IDLE;
      default:
        poll_next = eipv_pkg::POLL_IDLE;
    endcase
  end

  // Single poll line: chain position alone decides who answers
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      poll_reg <= eipv_pkg::POLL_IDLE;
      INT_POLL <= 1'b0;
    end
    else
    begin
      poll_reg <= poll_next;
      INT_POLL <= (poll_next == eipv_pkg::POLL_WAIT);
    end
  end

  // Device number latch; zero answers are dropped silently
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      int_addr_reg <= 8'h00;
    else if (poll_latch)
      int_addr_reg <= num_s2_reg;
  end

  // Pending external flag: new latch wins over CPU take
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      pend_reg    <= 1'b0;
      CPU_EXT_INT <= 1'b0;
    end
    else
    begin
      if (poll_latch)
        pend_reg <= 1'b1;
      else if (cmd == eipv_pkg::CMD_EXT_TAKE)
        pend_reg <= 1'b0;
      CPU_EXT_INT <= poll_latch || (pend_reg && cmd != eipv_pkg::CMD_EXT_TAKE);
    end
  end

  // ==========================================================
  // Status word
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      status_reg <= eipv_pkg::STATUS_RST;
    else if (cmd == eipv_pkg::CMD_EXT_TAKE && pend_reg)
      status_reg <= eipv_pkg::STATUS_EXTERNAL;
    else if (cmd == eipv_pkg::CMD_INTERNAL || cmd == eipv_pkg::CMD_STACK_OVF || trap_take)
      status_reg <= eipv_pkg::STATUS_INTERNAL;
    else if (wr_hit && ADR_I == eipv_pkg::OFS_LABEL && ext_act_reg && DAT_I[7:0] != eipv_pkg::SEG_INTERNAL)
      status_reg <= {status_reg[15:8], DAT_I[7:0]};
    else if (wr_hit && ADR_I == eipv_pkg::OFS_STATUS)
      status_reg <= wdata;
  end

  // ==========================================================
  // Vector and parameter
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      stt_reg      <= 8'h00;
      param_reg    <= 16'h0000;
      ics_mark_reg <= 1'b0;
    end
    else
    begin
      case (cmd)
        eipv_pkg::CMD_EXT_TAKE:
          if (pend_reg)
          begin
            stt_reg      <= 8'h00;
            param_reg    <= {8'h00, int_addr_reg};
            ics_mark_reg <= 1'b1;
          end
        eipv_pkg::CMD_INTERNAL:
        begin
          stt_reg      <= {3'b000, DAT_I[12:8]};
          param_reg    <= DAT_I[31:16];
          ics_mark_reg <= DAT_I[13];
        end
        eipv_pkg::CMD_STACK_OVF:
        begin
          stt_reg      <= eipv_pkg::STT_STACK_OVF;
          param_reg    <= DAT_I[31:16];
          ics_mark_reg <= 1'b1;
        end
        eipv_pkg::CMD_USER_TRAP:
          if (trap_take)
          begin
            stt_reg      <= eipv_pkg::STT_USER_TRAP;
            param_reg    <= {11'h000, DAT_I[12:8]};
            ics_mark_reg <= 1'b0;
          end
        default:
          stt_reg <= stt_reg;
      endcase
    end
  end

  // ==========================================================
  // Stack and dispatcher flags
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      ics_reg  <= 1'b0;
      disp_reg <= 1'b0;
    end
    else
    begin
      if ((cmd == eipv_pkg::CMD_EXT_TAKE && pend_reg) || cmd == eipv_pkg::CMD_STACK_OVF ||
          (cmd == eipv_pkg::CMD_INTERNAL && DAT_I[13]) || cmd == eipv_pkg::CMD_DISP_ENT)
        ics_reg <= 1'b1;
      else if (cmd == eipv_pkg::CMD_ICS_LEAVE)
        ics_reg <= 1'b0;
      if (cmd == eipv_pkg::CMD_DISP_ENT)
        disp_reg <= 1'b1;
      else if (cmd == eipv_pkg::CMD_DISP_END || (cmd == eipv_pkg::CMD_EXT_TAKE && pend_reg) ||
               cmd == eipv_pkg::CMD_INTERNAL || cmd == eipv_pkg::CMD_STACK_OVF || trap_take)
        disp_reg <= 1'b0;
    end
  end

  // ==========================================================
  // External handler tracking and controller reset
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      ext_act_reg     <= 1'b0;
      lbl_err_reg     <= 1'b0;
      dev_rst_reg     <= 1'b0;
      dev_rst_num_reg <= 8'h00;
    end
    else
    begin
      dev_rst_reg <= 1'b0;
      if (cmd == eipv_pkg::CMD_EXT_TAKE && pend_reg)
        ext_act_reg <= 1'b1;
      else if (cmd == eipv_pkg::CMD_INTERRUPT_EXIT_INSTRUCTION && ext_act_reg)
      begin
        ext_act_reg     <= 1'b0;
        dev_rst_reg     <= 1'b1;
        dev_rst_num_reg <= int_addr_reg;
      end
      // Device handler pointing into the internal segment is refused
      if (wr_hit && ADR_I == eipv_pkg::OFS_LABEL)
        lbl_err_reg <= ext_act_reg && (DAT_I[7:0] == eipv_pkg::SEG_INTERNAL);
    end
  end

  assign DEV_RESET     = dev_rst_reg;
  assign DEV_RESET_NUM = dev_rst_num_reg;

  // ==========================================================
  // Configuration and dispatcher marker word
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      cpu_sel_reg <= 1'b0;
      dq_b0_reg   <= 1'b0;
    end
    else
    begin
      if (wr_hit && ADR_I == eipv_pkg::OFS_CONFIG && SEL_I[0])
        cpu_sel_reg <= DAT_I[0];
      if (wr_hit && ADR_I == eipv_pkg::OFS_DQ_WORD && SEL_I[1])
        dq_b0_reg <= DAT_I[15];
    end
  end

  // ==========================================================
  // Read mux and acknowledge
  logic [31:0] rd_data;
  logic [15:0] ext_stat;
  logic [3:0]  qi_addr, zi_addr;

  assign qi_addr = cpu_sel_reg ? eipv_pkg::QI_ADDR_CPU2 : eipv_pkg::QI_ADDR_CPU1;
  assign zi_addr = cpu_sel_reg ? eipv_pkg::ZI_ADDR_CPU2 : eipv_pkg::ZI_ADDR_CPU1;

  always_comb
  begin
    ext_stat = 16'h0000;
    ext_stat[eipv_pkg::EXT_PEND_BIT]  = pend_reg;
    ext_stat[eipv_pkg::EXT_ICS_BIT]   = ics_reg;
    ext_stat[eipv_pkg::EXT_DISP_BIT]  = disp_reg;
    ext_stat[eipv_pkg::EXT_ACT_BIT]   = ext_act_reg;
    ext_stat[eipv_pkg::EXT_LBLER_BIT] = lbl_err_reg;
    case (ADR_I)
      eipv_pkg::OFS_STATUS:   rd_data = {16'h0000, status_reg};
      eipv_pkg::OFS_EXT_STAT: rd_data = {16'h0000, ext_stat};
      eipv_pkg::OFS_INT_ADDR: rd_data = {24'h000000, int_addr_reg};
      eipv_pkg::OFS_VECTOR:   rd_data = {param_reg, 8'h00, stt_reg};
      eipv_pkg::OFS_FRAME:
        rd_data = {16'h0000,
                   ics_mark_reg ? eipv_pkg::PARAM_OFS_ICS : eipv_pkg::PARAM_OFS_STD,
                   ics_mark_reg ? eipv_pkg::MARK_WORDS_ICS : eipv_pkg::MARK_WORDS_STD,
                   zi_addr, qi_addr};
      eipv_pkg::OFS_DRT_ADDR:
        rd_data = {drt_word(int_addr_reg, eipv_pkg::DRT_DATA_OFS),
                   drt_word(int_addr_reg, eipv_pkg::DRT_LABEL_OFS)};
      eipv_pkg::OFS_CONFIG:   rd_data = {31'h00000000, cpu_sel_reg};
      eipv_pkg::OFS_DQ_WORD:  rd_data = {16'h0000, dq_b0_reg, 15'h0000};
      default:                rd_data = 32'h00000000;
    endcase
  end

  // One wait-free answer per request; ack falls the cycle after
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      ack_reg <= 1'b0;
      DAT_O   <= 32'h00000000;
    end
    else
    begin
      ack_reg <= bus_req;
      if (bus_req && !WE_I)
        DAT_O <= rd_data;
    end
  end

  assign ACK_O = ack_reg;

endmodule : eipv_ctrl
`default_nettype wire

/* File: hw/eipv_pkg.sv */
// Package for the external interrupt poll and vectoring block.
// Assumes a 16-bit machine word; bit positions are MSB-first (machine bit 0 = index 15).
package eipv_pkg;
  // Wishbone byte offsets
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_EXT_STAT = 8'h04;
  localparam logic [7:0] OFS_INT_ADDR = 8'h08;
  localparam logic [7:0] OFS_CMD      = 8'h0C;
  localparam logic [7:0] OFS_VECTOR   = 8'h10;
  localparam logic [7:0] OFS_FRAME    = 8'h14;
  localparam logic [7:0] OFS_DRT_ADDR = 8'h18;
  localparam logic [7:0] OFS_CONFIG   = 8'h1C;
  localparam logic [7:0] OFS_DQ_WORD  = 8'h20;
  localparam logic [7:0] OFS_LABEL    = 8'h24;
  // Status word values and fields
  localparam logic [15:0] STATUS_RST      = 16'h0000;
  localparam logic [15:0] STATUS_INTERNAL = 16'h8001;
  localparam logic [15:0] STATUS_EXTERNAL = 16'hC000;
  localparam int          STATUS_TRAP_BIT = 13;
  // Extended status bit positions
  localparam int EXT_PEND_BIT  = 7;
  localparam int EXT_ICS_BIT   = 6;
  localparam int EXT_DISP_BIT  = 5;
  localparam int EXT_ACT_BIT   = 4;
  localparam int EXT_LBLER_BIT = 3;
  // Segments, vectors and trap causes
  localparam logic [7:0] SEG_INTERNAL    = 8'h01;
  localparam logic [7:0] STT_STACK_OVF   = 8'h18;
  localparam logic [7:0] STT_USER_TRAP   = 8'h19;
  localparam logic [4:0] TRAP_FIRST      = 5'h01;
  localparam logic [4:0] TRAP_GAP_LO     = 5'h05;
  localparam logic [4:0] TRAP_GAP_HI     = 5'h08;
  localparam logic [4:0] TRAP_LAST       = 5'h10;
  // Interrupt stack pointers in fixed memory
  localparam logic [3:0] QI_ADDR_CPU1    = 4'h5;
  localparam logic [3:0] ZI_ADDR_CPU1    = 4'h6;
  localparam logic [3:0] QI_ADDR_CPU2    = 4'h9;
  localparam logic [3:0] ZI_ADDR_CPU2    = 4'hA;
  // Stack marker layout
  localparam logic [3:0] MARK_WORDS_ICS  = 4'h6;
  localparam logic [3:0] MARK_WORDS_STD  = 4'h4;
  localparam logic [3:0] PARAM_OFS_ICS   = 4'h3;
  localparam logic [3:0] PARAM_OFS_STD   = 4'h1;
  // Device reference table: four words per entry
  localparam logic [15:0] DRT_LABEL_OFS  = 16'h0001;
  localparam logic [15:0] DRT_DATA_OFS   = 16'h0002;
  localparam int          DEVNUM_W       = 8;
  // Commands
  typedef enum logic [3:0] {
    CMD_NONE      = 4'h0,
    CMD_EXT_TAKE  = 4'h1,
    CMD_INTERNAL  = 4'h2,
    CMD_USER_TRAP = 4'h3,
    CMD_STACK_OVF = 4'h4,
    CMD_INTERRUPT_EXIT_INSTRUCTION      = 4'h5,
    CMD_DISP_ENT  = 4'h6,
    CMD_DISP_END  = 4'h7,
    CMD_ICS_LEAVE = 4'h8
  } eipv_cmd_t;
  // Poll sequencer, Gray from IDLE through WAIT to DROP
  typedef enum logic [1:0] {
    POLL_IDLE = 2'b00,
    POLL_WAIT = 2'b01,
    POLL_DROP = 2'b11
  } eipv_poll_t;
endpackage : eipv_pkg

/* File: verification/eipv_ctrl_props.sv */
// Port checker for the poll and vectoring controller.
// Assumes it is bound to eipv_ctrl and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module eipv_ctrl_props (
  // Clock and reset
  input wire logic        SYS_CLK,
  input wire logic        RST_N,
  // Wishbone
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic        WE_I,
  input wire logic [7:0]  ADR_I,
  input wire logic [3:0]  SEL_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire logic        ACK_O,
  // Poll chain and CPU
  input wire logic        INT_REQ,
  input wire logic        DEV_NUM_VALID,
  input wire logic [7:0]  DEV_NUM,
  input wire logic        INT_POLL,
  input wire logic        DEV_RESET,
  input wire logic [7:0]  DEV_RESET_NUM,
  input wire logic        CPU_EXT_INT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  logic wr_cmd;
  assign wr_cmd = CYC_I && STB_I && WE_I && !ACK_O && ADR_I == eipv_pkg::OFS_CMD;
  // ==========================================
  // Bus and poll timing
  property p_ack_next;
    CYC_I && STB_I && !ACK_O |=> ACK_O;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_poll_hold;
    INT_POLL && !DEV_NUM_VALID |=> INT_POLL;
  endproperty
  a_poll_hold: assert property (p_poll_hold) else $error("poll dropped early");
  property p_poll_drop;
    $rose(DEV_NUM_VALID) && INT_POLL |-> ##[1:5] !INT_POLL;
  endproperty
  a_poll_drop: assert property (p_poll_drop) else $error("poll not released");
  property p_no_poll;
    $rose(INT_POLL) |-> !CPU_EXT_INT && $past(INT_REQ, 2);
  endproperty
  a_no_poll: assert property (p_no_poll) else $error("poll without cause");
  // ==========================================
  // Answer handling
  property p_latch;
    $fell(INT_POLL) && DEV_NUM != 8'h00 |-> CPU_EXT_INT;
  endproperty
  a_latch: assert property (p_latch) else $error("cpu not told");
  property p_zero;
    $fell(INT_POLL) && DEV_NUM == 8'h00 |-> !CPU_EXT_INT;
  endproperty
  a_zero: assert property (p_zero) else $error("zero number taken");
  property p_cpu_hold;
    CPU_EXT_INT && !(wr_cmd && DAT_I[3:0] == eipv_pkg::CMD_EXT_TAKE) |=> CPU_EXT_INT;
  endproperty
  a_cpu_hold: assert property (p_cpu_hold) else $error("pending lost");
  property p_rst_cause;
    DEV_RESET |-> $past(wr_cmd) && $past(DAT_I[3:0]) == eipv_pkg::CMD_INTERRUPT_EXIT_INSTRUCTION;
  endproperty
  a_rst_cause: assert property (p_rst_cause) else $error("reset without exit");
  property p_rst_pulse;
    DEV_RESET |=> !DEV_RESET;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset too long");
endmodule : eipv_ctrl_props
bind eipv_ctrl eipv_ctrl_props u_props (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
  .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
  .INT_REQ(INT_REQ), .DEV_NUM_VALID(DEV_NUM_VALID), .DEV_NUM(DEV_NUM), .INT_POLL(INT_POLL),
  .DEV_RESET(DEV_RESET), .DEV_RESET_NUM(DEV_RESET_NUM), .CPU_EXT_INT(CPU_EXT_INT)
);
`default_nettype wire

/* File: verification/eipv_dev_model.sv */
// Two device controllers on the poll chain.
// Assumes set_req pulses; slot 0 sits nearest the poller.
`timescale 1ns/10ps
`default_nettype none
module eipv_dev_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Bench side
  input  wire logic [1:0] set_req,
  input  wire logic [7:0] num0,
  input  wire logic [7:0] num1,
  // Poll chain
  input  wire logic       int_poll,
  output var  logic       int_req,
  output var  logic       num_vld,
  output var  logic [7:0] dev_num
);
  logic [1:0] req_reg;
  logic       busy_reg;
  logic       sel_reg;
  logic [1:0] cnt_reg;
  logic [7:0] pat_reg;
  logic       take;
  logic       pick;
  // ==========================================
  // Requests
  assign take = !busy_reg && int_poll && req_reg != 2'b00;
  assign pick = !req_reg[0];
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      req_reg <= 2'b00;
    else
      req_reg <= (req_reg | set_req) & ~(take ? (pick ? 2'b10 : 2'b01) : 2'b00);
  end
  // ==========================================
  // Answer; number settles two cycles before valid
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      busy_reg <= 1'b0;
    else if (take)
    begin
      busy_reg <= 1'b1;
      sel_reg  <= pick;
      cnt_reg  <= 2'd0;
    end
    else if (busy_reg && cnt_reg != 2'd2)
      cnt_reg <= cnt_reg + 2'd1;
    else if (!int_poll)
      busy_reg <= 1'b0;
  end
  // Released number lines churn, never hold the old value
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      pat_reg <= 8'hA5;
    else
      pat_reg <= pat_reg + 8'h01;
  end
  assign int_req = |req_reg;
  assign num_vld = busy_reg && cnt_reg == 2'd2;
  assign dev_num = busy_reg ? (sel_reg ? num1 : num0) : pat_reg;
endmodule : eipv_dev_model
`default_nettype wire

/* File: verification/tb_eipv_ctrl.sv */
// Bench for the poll and vectoring controller.
// Assumes the checker is bound and the device model stands on the chain.
`timescale 1ns/10ps
`default_nettype none
module tb_eipv_ctrl;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic        ack;
  logic        int_req;
  logic        num_vld;
  logic [7:0]  num;
  logic        poll;
  logic        dev_rst;
  logic [7:0]  dev_rst_num;
  logic        cpu_int;
  logic [1:0]  set_req = 2'b00;
  logic [7:0]  num0 = 8'h09;
  logic [7:0]  num1 = 8'h02;
  logic [7:0]  rst_got;
  int          rst_cnt = 0;
  int          err_count = 0;
  int          n_tests = 0;
  logic [4:0]  cause [6] = '{5'h06, 5'h01, 5'h05, 5'h08, 5'h10, 5'h11};
  always #10 sys_clk = ~sys_clk;
  eipv_ctrl dut_u (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(4'hF), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .INT_REQ(int_req),
    .DEV_NUM_VALID(num_vld), .DEV_NUM(num), .INT_POLL(poll), .DEV_RESET(dev_rst),
    .DEV_RESET_NUM(dev_rst_num), .CPU_EXT_INT(cpu_int)
  );
  eipv_dev_model dev_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .set_req(set_req), .num0(num0), .num1(num1),
    .int_poll(poll), .int_req(int_req), .num_vld(num_vld), .dev_num(num)
  );
  always @(posedge sys_clk)
  begin
    if (dev_rst === 1'b1)
    begin
      rst_cnt <= rst_cnt + 1;
      rst_got <= dev_rst_num;
    end
  end
  // ==========================================
  // Bus cycle, compare and verdict
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge sys_clk);
    while (ack !== 1'b1)
      @(posedge sys_clk);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), rd & m, e);
  endtask : rdchk
  task automatic wait_int;
    while (cpu_int !== 1'b1)
      @(posedge sys_clk);
  endtask : wait_int
  task automatic give_verdict;
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  initial
  begin
    #1000000;
    err_count++;
    give_verdict();
  end
  // ==========================================
  // Scenarios
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdchk(eipv_pkg::OFS_EXT_STAT, 32'hFFFF, 32'h0);
    @(posedge sys_clk);
    set_req <= 2'b11;
    @(posedge sys_clk);
    set_req <= 2'b00;
    wait_int();
    rdchk(eipv_pkg::OFS_INT_ADDR, 32'hFF, 32'h09);
    rdchk(eipv_pkg::OFS_EXT_STAT, 32'h80, 32'h80);
    wb(1'b1, eipv_pkg::OFS_CMD, 32'h1);
    rdchk(eipv_pkg::OFS_STATUS, 32'hFFFF, 32'hC000);
    rdchk(eipv_pkg::OFS_VECTOR, 32'hFFFF0000, 32'h00090000);
    rdchk(eipv_pkg::OFS_FRAME, 32'hFFFF, 32'h3665);
    rdchk(eipv_pkg::OFS_EXT_STAT, 32'h70, 32'h50);
    wb(1'b1, eipv_pkg::OFS_LABEL, 32'h1);
    rdchk(eipv_pkg::OFS_EXT_STAT, 32'h08, 32'h08);
    wb(1'b1, eipv_pkg::OFS_LABEL, 32'h3);
    rdchk(eipv_pkg::OFS_STATUS, 32'hFF, 32'h03);
    wait_int();
    rdchk(eipv_pkg::OFS_INT_ADDR, 32'hFF, 32'h02);
    wb(1'b1, eipv_pkg::OFS_CMD, 32'h1);
    rdchk(eipv_pkg::OFS_DRT_ADDR, 32'hFFFFFFFF, {16'd10, 16'd9});
    wb(1'b1, eipv_pkg::OFS_CMD, 32'h5);
    @(posedge sys_clk);
    chk("reset count", rst_cnt, 1);
    chk("reset number", rst_got, 32'h02);
    num0 <= 8'h00;
    set_req <= 2'b01;
    @(posedge sys_clk);
    set_req <= 2'b00;
    while (poll !== 1'b1)
      @(posedge sys_clk);
    while (poll !== 1'b0)
      @(posedge sys_clk);
    repeat (3) @(posedge sys_clk);
    chk("cpu interrupt", cpu_int, 1'b0);
    rdchk(eipv_pkg::OFS_INT_ADDR, 32'hFF, 32'h02);
    wb(1'b1, eipv_pkg::OFS_CMD, 32'h12340502);
    rdchk(eipv_pkg::OFS_STATUS, 32'hFFFF, 32'h8001);
    rdchk(eipv_pkg::OFS_VECTOR, 32'hFFFF00FF, 32'h12340005);
    wb(1'b1, eipv_pkg::OFS_CMD, 32'h4);
    rdchk(eipv_pkg::OFS_VECTOR, 32'hFF, 32'h18);
    rdchk(eipv_pkg::OFS_EXT_STAT, 32'h40, 32'h40);
    wb(1'b1, eipv_pkg::OFS_CMD, 32'h0103);
    rdchk(eipv_pkg::OFS_VECTOR, 32'hFF, 32'h18);
    for (int i = 0; i < 6; i++)
    begin
      wb(1'b1, eipv_pkg::OFS_STATUS, 32'h2000);
      wb(1'b1, eipv_pkg::OFS_CMD, {19'h0, cause[i], 8'h03});
      if (i == 0 || i == 5)
        rdchk(eipv_pkg::OFS_VECTOR, 32'hFF, (i == 0) ? 32'h18 : 32'h19);
      else
        rdchk(eipv_pkg::OFS_VECTOR, 32'hFFFF00FF, {11'h0, cause[i], 16'h0019});
    end
    wb(1'b1, eipv_pkg::OFS_CMD, 32'h6);
    rdchk(eipv_pkg::OFS_EXT_STAT, 32'h60, 32'h60);
    wb(1'b1, eipv_pkg::OFS_CMD, 32'h7);
    rdchk(eipv_pkg::OFS_EXT_STAT, 32'h20, 32'h00);
    wb(1'b1, eipv_pkg::OFS_CMD, 32'h6);
    wb(1'b1, eipv_pkg::OFS_CMD, 32'h2);
    rdchk(eipv_pkg::OFS_EXT_STAT, 32'h20, 32'h00);
    wb(1'b1, eipv_pkg::OFS_CMD, 32'h8);
    rdchk(eipv_pkg::OFS_EXT_STAT, 32'h40, 32'h00);
    wb(1'b1, eipv_pkg::OFS_DQ_WORD, 32'hFFFF);
    rdchk(eipv_pkg::OFS_DQ_WORD, 32'hFFFFFFFF, 32'h8000);
    wb(1'b1, eipv_pkg::OFS_CONFIG, 32'h1);
    rdchk(eipv_pkg::OFS_FRAME, 32'hFF, 32'hA9);
    wb(1'b1, 8'h3C, 32'hFFFF);
    rdchk(8'h3C, 32'hFFFFFFFF, 32'h0);
    give_verdict();
  end
endmodule : tb_eipv_ctrl
`default_nettype wire
